/* ocl_pkg.sv */
package ocl_pkg;

    // ========================================
    // Command encodings
    localparam logic [7:0] OCL_CMD_CAL_ENTER = 8'h82;
    localparam logic [4:0] OCL_PWR_PATTERN = 5'h05;
    localparam int OCL_PWR_HI_POS = 7;
    localparam int OCL_PWR_PAT_LO = 3;
    localparam int OCL_PWR_MARK_POS = 0;
    localparam int OCL_PWR_FIELD_HI = 2;
    localparam int OCL_PWR_FIELD_LO = 1;
    localparam int OCL_CONT_POS = 7;
    localparam int OCL_DATA_POS = 0;

    // ========================================
    // Calibration shift register layout
    localparam int OCL_SR_W = 9;
    localparam int OCL_OFS_HI = 8;
    localparam int OCL_OFS_LO = 4;
    localparam int OCL_TC_HI = 3;
    localparam int OCL_TC_LO = 1;
    localparam int OCL_SEAL_POS = 0;
    localparam logic [8:0] OCL_SR_RESET = 9'h000;

    // ========================================
    // Link byte framing
    localparam int OCL_BIT_CNT_W = 3;
    localparam logic [2:0] OCL_LAST_BIT = 3'h7;

    // ========================================
    // Reload timing
    localparam int OCL_CLK_PERIOD_NS = 20;
    localparam int OCL_REFRESH_TIME_NS = 5000000;
    localparam int OCL_REFRESH_CYCLES_DEF =
        OCL_REFRESH_TIME_NS / OCL_CLK_PERIOD_NS;
    localparam int OCL_REFRESH_CNT_W = 18;

endpackage : ocl_pkg

module ocl_sync2
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Level crossing
    input wire logic async_in,
    output logic sync_out
);
    logic meta_reg;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // ocl_sync2

/* ocl_loader.sv */
// Summary of operation
// - Command 1000_0010 with select low and write enters calibration mode.
// - Entry command ignored while the seal bit reads one.
// - In calibration mode command bytes are shift data, not instructions.
// - Byte bit 7 one stays in mode, zero leaves after data bit.
// - Reset clears calibration mode and restores normal decoding.
// - Calibration bytes come with select low; six middle bits ignored.
// - Byte bit 0 shifts into the register, sampled at rising clock.
// - Command 0010_1xx1 forces reload of the register from cells.
// - Reload finishes within 5 ms of its trigger.
// - Commands keep being accepted and executed during a reload.
// - Each multiplier on/off command outside power-save also triggers the reload.
// - In power-save the power field updates but reload is skipped.
// - Order is offset bits, then coefficient bits, seal bit last.
// - Bits move serially; fields valid only after nine shifts.
// - Register contents drive calibration outputs directly.
// - Nine bits: 5-bit offset, 3-bit coefficient, one seal bit.
// - Register resets to zero; entry disabled until a reload completes.
// - Leaving power-save also starts a reload from the cells.
module ocl_loader
    import ocl_pkg::*;
#(
    parameter int REFRESH_CYCLES = ocl_pkg::OCL_REFRESH_CYCLES_DEF
)
(
    // System clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Serial command link
    input wire logic link_sclk,
    input wire logic link_cs_n,
    input wire logic link_sdin,
    input wire logic link_dc,
    input wire logic link_rd,
    // Power state and cells
    input wire logic power_save,
    input wire logic [ocl_pkg::OCL_SR_W-1:0] otp_cells,
    // Calibration outputs
    output logic [4:0] supply_offset_code,
    output logic [2:0] temp_coeff_default,
    output logic seal_bit,
    // Status
    output logic calibration_mode,
    output logic refresh_busy,
    output logic refresh_done,
    output logic [1:0] power_ctrl_field
);
    import ocl_pkg::*;

    localparam logic [OCL_REFRESH_CNT_W-1:0] REFRESH_LAST =
        OCL_REFRESH_CNT_W'(REFRESH_CYCLES - 1);

    // ========================================
    // Link domain: byte assembly
    logic link_rst;
    logic [7:0] link_shift_reg;
    logic [OCL_BIT_CNT_W-1:0] link_cnt_reg;
    logic link_dc_reg;
    logic link_rd_reg;
    logic link_full_reg;
    logic [7:0] link_byte_reg;
    logic link_byte_dc_reg;
    logic link_byte_rd_reg;
    logic link_tog_reg;

    ocl_sync2 u_link_rst
    (
        .clk(link_sclk),
        .rst(1'b0),
        .async_in(sys_rst),
        .sync_out(link_rst)
    );

    always_ff @(posedge link_sclk)
    begin
        if (link_rst)
        begin
            link_shift_reg <= '0;
            link_cnt_reg <= '0;
            link_dc_reg <= 1'b0;
            link_rd_reg <= 1'b0;
        end
        else if (!link_cs_n)
        begin
            link_shift_reg <= {link_shift_reg[6:0], link_sdin};
            link_cnt_reg <= link_cnt_reg + 1'b1;
            link_dc_reg <= link_dc;
            link_rd_reg <= link_rd;
        end
    end

    always_ff @(posedge link_sclk)
    begin
        if (link_rst)
            link_full_reg <= 1'b0;
        else
            link_full_reg <= !link_cs_n && (link_cnt_reg == OCL_LAST_BIT);
    end

    // Hand the byte over on the falling edge
    always_ff @(negedge link_sclk)
    begin
        if (link_rst)
        begin
            link_byte_reg <= '0;
            link_byte_dc_reg <= 1'b0;
            link_byte_rd_reg <= 1'b0;
            link_tog_reg <= 1'b0;
        end
        else if (link_full_reg)
        begin
            link_byte_reg <= link_shift_reg;
            link_byte_dc_reg <= link_dc_reg;
            link_byte_rd_reg <= link_rd_reg;
            link_tog_reg <= !link_tog_reg;
        end
    end

    // ========================================
    // System domain: command arrival
    logic tog_sync;
    logic tog_seen_reg;
    logic cmd_valid;
    logic cmd_write;
    logic [7:0] cmd_byte;

    ocl_sync2 u_tog_sync
    (
        .clk(ref_clk),
        .rst(sys_rst),
        .async_in(link_tog_reg),
        .sync_out(tog_sync)
    );

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            tog_seen_reg <= 1'b0;
        else
            tog_seen_reg <= tog_sync;
    end

    // Held byte is stable for a whole byte time after the toggle
    assign cmd_valid = tog_sync ^ tog_seen_reg;
    assign cmd_write = !link_byte_dc_reg && !link_byte_rd_reg;
    assign cmd_byte = link_byte_reg;

    // ========================================
    // Decode
    logic cal_byte;
    logic enter_cmd;
    logic pwr_cmd;
    logic pwr_save_d_reg;
    logic refresh_start;
    logic refresh_load;
    logic [OCL_SR_W-1:0] sr_reg;
    logic [OCL_REFRESH_CNT_W-1:0] refresh_cnt_reg;

    assign cal_byte = cmd_valid && cmd_write && calibration_mode;
    assign enter_cmd = cmd_valid && cmd_write && !calibration_mode
        && (cmd_byte == OCL_CMD_CAL_ENTER);
    assign pwr_cmd = cmd_valid && cmd_write && !calibration_mode
        && (cmd_byte[OCL_PWR_HI_POS:OCL_PWR_PAT_LO] == OCL_PWR_PATTERN)
        && cmd_byte[OCL_PWR_MARK_POS];
    // Reload on power command unless saving power, or on save exit
    assign refresh_start = (pwr_cmd && !power_save)
        || (pwr_save_d_reg && !power_save);
    assign refresh_load = refresh_busy && (refresh_cnt_reg == REFRESH_LAST);

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            pwr_save_d_reg <= 1'b0;
        else
            pwr_save_d_reg <= power_save;
    end

    // ========================================
    // Mode control
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            calibration_mode <= 1'b0;
        else if (enter_cmd && refresh_done && !sr_reg[OCL_SEAL_POS])
            calibration_mode <= 1'b1;
        else if (cal_byte && !cmd_byte[OCL_CONT_POS])
            calibration_mode <= 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            power_ctrl_field <= '0;
        else if (pwr_cmd)
            power_ctrl_field <= cmd_byte[OCL_PWR_FIELD_HI:OCL_PWR_FIELD_LO];
    end

    // ========================================
    // Reload sequencer
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            refresh_busy <= 1'b0;
            refresh_cnt_reg <= '0;
        end
        else if (refresh_start)
        begin
            refresh_busy <= 1'b1;
            refresh_cnt_reg <= '0;
        end
        else if (refresh_load)
            refresh_busy <= 1'b0;
        else if (refresh_busy)
            refresh_cnt_reg <= refresh_cnt_reg + 1'b1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            refresh_done <= 1'b0;
        else if (refresh_load)
            refresh_done <= 1'b1;
    end

    // ========================================
    // Calibration shift register
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            sr_reg <= OCL_SR_RESET;
        else if (refresh_load)
            sr_reg <= otp_cells;
        else if (cal_byte)
            sr_reg <= {sr_reg[OCL_SR_W-2:0], cmd_byte[OCL_DATA_POS]};
    end

    // Outputs follow the register with no further storage
    assign supply_offset_code = sr_reg[OCL_OFS_HI:OCL_OFS_LO];
    assign temp_coeff_default = sr_reg[OCL_TC_HI:OCL_TC_LO];
    assign seal_bit = sr_reg[OCL_SEAL_POS];

    // ========================================
    // Checks
    property p_enter;
        @(posedge ref_clk) disable iff (sys_rst)
        enter_cmd && refresh_done && !seal_bit |=> calibration_mode;
    endproperty
    a_enter: assert property (p_enter)
        else $error("Entry command did not enter calibration mode");

    property p_sealed;
        @(posedge ref_clk) disable iff (sys_rst)
        enter_cmd && (seal_bit || !refresh_done) |=> !calibration_mode;
    endproperty
    a_sealed: assert property (p_sealed)
        else $error("Calibration mode entered while sealed or unloaded");

    property p_no_decode;
        @(posedge ref_clk) disable iff (sys_rst)
        calibration_mode && cmd_valid |=> $stable(power_ctrl_field);
    endproperty
    a_no_decode: assert property (p_no_decode)
        else $error("Instruction decoded during calibration mode");

    property p_exit;
        @(posedge ref_clk) disable iff (sys_rst)
        cal_byte && !cmd_byte[OCL_CONT_POS] |=> !calibration_mode;
    endproperty
    a_exit: assert property (p_exit)
        else $error("Calibration mode not left on clear continuation");

    property p_reset;
        @(posedge ref_clk)
        sys_rst |=> !calibration_mode && !refresh_done
            && sr_reg == OCL_SR_RESET;
    endproperty
    a_reset: assert property (p_reset)
        else $error("Reset did not clear mode and register");

    property p_shift;
        @(posedge ref_clk) disable iff (sys_rst)
        cal_byte && !refresh_load
            |=> sr_reg == {$past(sr_reg[OCL_SR_W-2:0]),
            $past(cmd_byte[OCL_DATA_POS])};
    endproperty
    a_shift: assert property (p_shift)
        else $error("Data bit not shifted into the register");

    property p_reload_bound;
        @(posedge ref_clk) disable iff (sys_rst)
        refresh_busy |-> refresh_cnt_reg <= REFRESH_LAST;
    endproperty
    a_reload_bound: assert property (p_reload_bound)
        else $error("Reload exceeded its time budget");

    property p_reload_load;
        @(posedge ref_clk) disable iff (sys_rst)
        refresh_load && !refresh_start
            |=> !refresh_busy && refresh_done && sr_reg == $past(otp_cells);
    endproperty
    a_reload_load: assert property (p_reload_load)
        else $error("Reload did not load the cells");

    property p_save_skip;
        @(posedge ref_clk) disable iff (sys_rst)
        pwr_cmd && power_save && pwr_save_d_reg && !refresh_busy
            |=> !refresh_busy
            && power_ctrl_field
            == $past(cmd_byte[OCL_PWR_FIELD_HI:OCL_PWR_FIELD_LO]);
    endproperty
    a_save_skip: assert property (p_save_skip)
        else $error("Power-save command handled wrongly");

    property p_save_exit;
        @(posedge ref_clk) disable iff (sys_rst)
        $fell(power_save) |-> ##1 refresh_busy;
    endproperty
    a_save_exit: assert property (p_save_exit)
        else $error("Leaving power-save did not start a reload");

    property p_busy_cmd;
        @(posedge ref_clk) disable iff (sys_rst)
        pwr_cmd && refresh_busy
            |=> power_ctrl_field
            == $past(cmd_byte[OCL_PWR_FIELD_HI:OCL_PWR_FIELD_LO]);
    endproperty
    a_busy_cmd: assert property (p_busy_cmd)
        else $error("Command refused while a reload runs");

    property p_restart;
        @(posedge ref_clk) disable iff (sys_rst)
        pwr_cmd && !power_save |=> refresh_busy && refresh_cnt_reg == '0;
    endproperty
    a_restart: assert property (p_restart)
        else $error("Power command did not start a reload");

    property p_ignore;
        @(posedge ref_clk) disable iff (sys_rst)
        cmd_valid && !cmd_write && !refresh_load
            |=> $stable(calibration_mode) && $stable(sr_reg)
            && $stable(power_ctrl_field);
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("Byte with wrong select or direction acted");

    property p_stay;
        @(posedge ref_clk) disable iff (sys_rst)
        cal_byte && cmd_byte[OCL_CONT_POS] |=> calibration_mode;
    endproperty
    a_stay: assert property (p_stay)
        else $error("Calibration mode left with continuation set");

endmodule // ocl_loader

/* ocl_host_model.sv */
// ========================================
// Host side of the serial command link
module ocl_host_model
(
    // Link
    output logic link_sclk,
    output logic link_cs_n,
    output logic link_sdin,
    output logic link_dc,
    output logic link_rd
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam real HALF_NS = 62.5;

    initial
    begin
        link_sclk = 1'b0;
        link_cs_n = 1'b1;
        link_sdin = 1'b0;
        link_dc = 1'b1;
        link_rd = 1'b1;
    end

    // Clock pulses with no frame, for reset
    task automatic idle_pulses(input int n);
        for (int i = 0; i < n; i++)
        begin
            link_sdin = ~link_sdin;
            #HALF_NS link_sclk = 1'b1;
            #HALF_NS link_sclk = 1'b0;
        end
    endtask

    // One whole byte, MSB first, clock idle low
    task automatic send_byte(input logic [7:0] b, input logic dc,
                             input logic rd);
        // Gap so a released frame is not reopened in the same step
        #HALF_NS;
        link_cs_n = 1'b0;
        link_dc = dc;
        link_rd = rd;
        for (int i = 7; i >= 0; i--)
        begin
            link_sdin = b[i];
            #HALF_NS link_sclk = 1'b1;
            #HALF_NS link_sclk = 1'b0;
        end
        #5;
        // Released lines must not keep their last value
        link_cs_n = 1'b1;
        link_sdin = ~link_sdin;
        link_dc = ~dc;
        link_rd = ~rd;
    endtask
endmodule // ocl_host_model

/* test_otp_calibration_shift_loader.sv */
module test_otp_calibration_shift_loader;
    timeunit 1ns;
    timeprecision 100ps;
    import ocl_pkg::*;
    localparam int RC = 200;
    typedef struct packed {
        logic [7:0] b;
        logic dc;
        logic rd;
        logic mode;
    } ocl_row_t;
    logic ref_clk, sys_rst, power_save;
    logic [OCL_SR_W-1:0] otp_cells, sr;
    logic link_sclk, link_cs_n, link_sdin, link_dc, link_rd;
    logic [4:0] supply_offset_code;
    logic [2:0] temp_coeff_default;
    logic [1:0] power_ctrl_field;
    logic seal_bit, calibration_mode, refresh_busy, refresh_done;
    int err_total, checks;
    ocl_row_t rows [12] = '{'{8'h82, 1'b1, 1'b0, 1'b0},
        '{8'h82, 1'b0, 1'b1, 1'b0}, '{8'h82, 1'b0, 1'b0, 1'b1},
        '{8'h81, 1'b0, 1'b0, 1'b1}, '{8'hff, 1'b0, 1'b0, 1'b1},
        '{8'ha5, 1'b0, 1'b0, 1'b1}, '{8'h80, 1'b0, 1'b0, 1'b1},
        '{8'hfe, 1'b0, 1'b0, 1'b1}, '{8'h80, 1'b0, 1'b0, 1'b1},
        '{8'hab, 1'b0, 1'b0, 1'b1}, '{8'hc0, 1'b0, 1'b0, 1'b1},
        '{8'h2d, 1'b0, 1'b0, 1'b0}};

    assign sr = {supply_offset_code, temp_coeff_default, seal_bit};

    ocl_host_model host (.link_sclk(link_sclk), .link_cs_n(link_cs_n),
        .link_sdin(link_sdin), .link_dc(link_dc), .link_rd(link_rd));

    ocl_loader #(.REFRESH_CYCLES(RC)) uut (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .link_sclk(link_sclk), .link_cs_n(link_cs_n),
        .link_sdin(link_sdin), .link_dc(link_dc), .link_rd(link_rd),
        .power_save(power_save), .otp_cells(otp_cells),
        .supply_offset_code(supply_offset_code),
        .temp_coeff_default(temp_coeff_default), .seal_bit(seal_bit),
        .calibration_mode(calibration_mode), .refresh_busy(refresh_busy),
        .refresh_done(refresh_done), .power_ctrl_field(power_ctrl_field));

    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // ========================================
    // Helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic check_bit(input string name, input logic e, input logic g);
        checks++;
        if (g !== e)
        begin
            $display("wrong value %s expected %b seen %b", name, e, g);
            err_total++;
        end
    endtask

    task automatic check_vec(input string name, input logic [8:0] e,
                             input logic [8:0] g);
        checks++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", name, e, g);
            err_total++;
        end
    endtask

    task automatic cmd(input logic [7:0] b);
        host.send_byte(b, 1'b0, 1'b0);
        cyc(6);
    endtask

    task automatic reset_dut();
        @(posedge ref_clk) sys_rst <= 1'b1;
        fork
            cyc(5);
            host.idle_pulses(4);
        join
        @(posedge ref_clk) sys_rst <= 1'b0;
        host.idle_pulses(3);
        cyc(2);
    endtask

    // Count reload length, then compare loaded cells
    task automatic wait_reload(input logic full);
        int n;
        int k;
        n = 0;
        k = 0;
        while (refresh_busy !== 1'b1 && k < 10)
        begin
            cyc(1);
            k++;
        end
        while (refresh_busy === 1'b1 && n < 1000)
        begin
            cyc(1);
            n++;
        end
        if (full)
            check_vec("busy_len", 9'(RC), 9'(n));
        check_bit("done", 1'b1, refresh_done);
        check_vec("sr", otp_cells, sr);
    endtask

    task automatic final_report();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        #1000000;
        err_total++;
        final_report();
    end

    // ========================================
    // Main sequence
    initial
    begin
        sys_rst = 1'b1;
        power_save = 1'b0;
        otp_cells = 9'h0c4;
        err_total = 0;
        checks = 0;
        reset_dut();
        check_vec("sr", 9'h000, sr);
        check_bit("done", 1'b0, refresh_done);
        cmd(8'h82);
        check_bit("mode", 1'b0, calibration_mode);
        host.send_byte(8'h2b, 1'b0, 1'b0);
        wait_reload(1'b1);
        check_vec("field", 9'h001, 9'(power_ctrl_field));
        foreach (rows[i])
        begin
            host.send_byte(rows[i].b, rows[i].dc, rows[i].rd);
            cyc(6);
            check_bit("mode", rows[i].mode, calibration_mode);
        end
        check_vec("sr", 9'h1c5, sr);
        check_vec("field", 9'h001, 9'(power_ctrl_field));
        @(posedge ref_clk) otp_cells <= 9'h0a6;
        power_save <= 1'b1;
        cmd(8'h2d);
        check_vec("field", 9'h002, 9'(power_ctrl_field));
        check_bit("busy", 1'b0, refresh_busy);
        @(posedge ref_clk) power_save <= 1'b0;
        wait_reload(1'b1);
        host.send_byte(8'h29, 1'b0, 1'b0);
        host.send_byte(8'h2f, 1'b0, 1'b0);
        cyc(6);
        check_bit("busy", 1'b1, refresh_busy);
        check_vec("field", 9'h003, 9'(power_ctrl_field));
        wait_reload(1'b0);
        cmd(8'h82);
        check_bit("mode", 1'b1, calibration_mode);
        reset_dut();
        check_bit("mode", 1'b0, calibration_mode);
        check_vec("sr", 9'h000, sr);
        @(posedge ref_clk) otp_cells <= 9'h0a7;
        host.send_byte(8'h2b, 1'b0, 1'b0);
        wait_reload(1'b1);
        cmd(8'h82);
        check_bit("mode", 1'b0, calibration_mode);
        final_report();
    end
endmodule // test_otp_calibration_shift_loader
